// ---- acd_pkg.sv ----
// Purpose: Constants and types for the accessory detect timing block
// Assumes: 50 MHz system clock
// Notes:   Times are kept as printed, cycle counts derive from them
package acd_pkg;

    // =========================================================
    // Control link
    // =========================================================
    localparam logic [6:0] SLV_ADDR = 7'h25;
    localparam int unsigned CLK_NS    = 20;
    localparam int unsigned CLK_KHZ   = 50000;
    localparam int unsigned GLITCH_NS = 50;
    localparam int unsigned FLT_CYC   = (GLITCH_NS + CLK_NS - 1) / CLK_NS;

    // =========================================================
    // Detection and interrupt timing
    // =========================================================
    localparam int unsigned INT_DLY_MS  = 10;
    localparam int unsigned SDP_MS      = 130;
    localparam int unsigned CDP_MS      = 170;
    localparam int unsigned JIG_MS      = 200;
    localparam int unsigned INT_DLY_CYC = INT_DLY_MS * CLK_KHZ;
    localparam int unsigned SDP_CYC     = SDP_MS * CLK_KHZ;
    localparam int unsigned CDP_CYC     = CDP_MS * CLK_KHZ;
    localparam int unsigned JIG_CYC     = JIG_MS * CLK_KHZ;
    localparam int unsigned CNT_W       = 24;

    // =========================================================
    // Register map
    // =========================================================
    localparam logic [7:0] REG_ID    = 8'h01;
    localparam logic [7:0] REG_CTRL  = 8'h02;
    localparam logic [7:0] REG_INT   = 8'h03;
    localparam logic [7:0] REG_DEV1  = 8'h0A;
    localparam logic [7:0] CTRL_RST  = 8'h05;
    localparam int unsigned CTRL_MASK_BIT = 0;
    localparam int unsigned CTRL_AUTO_BIT = 2;
    localparam int unsigned CTRL_OPEN_BIT = 4;
    localparam int unsigned INT_ATT_BIT   = 0;
    localparam int unsigned INT_DET_BIT   = 1;
    localparam int unsigned DEV1_SDP_BIT  = 2;
    localparam int unsigned DEV1_CDP_BIT  = 5;

    typedef struct packed {
        logic vbus;
        logic sdp;
        logic cdp;
        logic jig;
    } acd_acc_s;

    typedef enum {
        S_IDLE, S_ADDR, S_ACK_A, S_REG, S_ACK_R,
        S_WDATA, S_ACK_W, S_RDATA, S_RACK
    } acd_i2c_e;

endpackage

// ---- acd_top.sv ----
// Purpose: Accessory detect timing with two-wire control slave
// Assumes: Pins are asynchronous to clk_i; sda is open drain
// Notes:   Long delays are parameters so simulation can shorten them
//
// Behaviour
// - Answer only to address 0100101; eighth bit selects read or write.
// - Reject glitches up to 50 ns on serial clock and data inputs.
// - Event while masked: interrupt goes low 10 ms after mask clears.
// - Standard port: close USB switch 130 ms after bus power valid.
// - Charging port: close USB switch 170 ms after bus power valid.
// - Jig with bus power: assert jig output 200 ms after power valid.
// - Jig without bus power: assert jig output after 200 ms detection.
// - Masked: never interrupt; unmasked: interrupt on attach or detach, not when a read clears the flags.
// - Set attach flag on attach, detach flag on removal; read clears.
`timescale 1ns/100ps
module acd_top #(
    parameter int unsigned P_INT_DLY_CYC = acd_pkg::INT_DLY_CYC,
    parameter int unsigned P_SDP_CYC     = acd_pkg::SDP_CYC,
    parameter int unsigned P_CDP_CYC     = acd_pkg::CDP_CYC,
    parameter int unsigned P_JIG_CYC     = acd_pkg::JIG_CYC,
    parameter logic [7:0]  P_DEV_ID      = 8'h5A  // Arbitrary value
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    input  wire acd_pkg::acd_acc_s acc_i,
    output logic                   usb_switch_closed_o,
    output logic                   factory_jig_o,
    output logic                   host_interrupt_n_o
);

    localparam int unsigned W = acd_pkg::CNT_W;

    // =========================================================
    // Input synchronisers and glitch filter
    // =========================================================
    logic [1:0]        scl_sy_r;
    logic [1:0]        sda_sy_r;
    acd_pkg::acd_acc_s acc_s1_r;
    acd_pkg::acd_acc_s acc_r;
    logic [1:0]        scl_fc_r;
    logic [1:0]        sda_fc_r;
    logic              scl_f_r;
    logic              sda_f_r;
    logic              scl_d_r;
    logic              sda_d_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_sy_r <= 2'h3;
            sda_sy_r <= 2'h3;
            acc_s1_r <= '0;
            acc_r    <= '0;
        end
        else
        begin
            scl_sy_r <= {scl_sy_r[0], scl_i};
            sda_sy_r <= {sda_sy_r[0], sda_i};
            acc_s1_r <= acc_i;
            acc_r    <= acc_s1_r;
        end
    end

    // New level taken only after FLT_CYC+1 agreeing samples
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_fc_r <= 2'h0;
            sda_fc_r <= 2'h0;
            scl_f_r  <= 1'b1;
            sda_f_r  <= 1'b1;
            scl_d_r  <= 1'b1;
            sda_d_r  <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_f_r;
            sda_d_r <= sda_f_r;
            if (scl_sy_r[1] == scl_f_r)
                scl_fc_r <= 2'h0;
            else if (scl_fc_r == 2'(acd_pkg::FLT_CYC))
            begin
                scl_f_r  <= scl_sy_r[1];
                scl_fc_r <= 2'h0;
            end
            else
                scl_fc_r <= scl_fc_r + 2'h1;
            if (sda_sy_r[1] == sda_f_r)
                sda_fc_r <= 2'h0;
            else if (sda_fc_r == 2'(acd_pkg::FLT_CYC))
            begin
                sda_f_r  <= sda_sy_r[1];
                sda_fc_r <= 2'h0;
            end
            else
                sda_fc_r <= sda_fc_r + 2'h1;
        end
    end

    chk_scl_glitch_reject: assert property (@(posedge clk_i) disable iff (rst_i)
        !$stable(scl_f_r) |-> $past(scl_sy_r[1], 1) == scl_f_r
            && $past(scl_sy_r[1], 2) == scl_f_r
            && $past(scl_sy_r[1], 3) == scl_f_r
            && $past(scl_sy_r[1], 4) == scl_f_r)
        else $error("scl level taken from a short pulse");

    wire scl_rise = scl_f_r & ~scl_d_r;
    wire scl_fall = ~scl_f_r & scl_d_r;
    wire i2c_start = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
    wire i2c_stop  = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;

    // =========================================================
    // Two-wire slave and registers
    // =========================================================
    acd_pkg::acd_i2c_e st_r;
    logic [3:0]        bit_cnt_r;
    logic [7:0]        shift_r;
    logic [7:0]        tx_r;
    logic [7:0]        ptr_r;
    logic [7:0]        ctrl_r;
    logic              rw_r;
    logic              nack_r;
    logic              oe_r;
    logic              rd_clr_r;
    logic              att_r;
    logic              det_r;
    logic              closed_r;
    logic              jig_r;
    logic [7:0]        ptr_inc;

    assign ptr_inc = ptr_r + 8'h01;
    wire mask_r = ctrl_r[acd_pkg::CTRL_MASK_BIT];

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            acd_pkg::REG_ID:   d = P_DEV_ID;
            acd_pkg::REG_CTRL: d = ctrl_r;
            acd_pkg::REG_INT:
            begin
                d[acd_pkg::INT_ATT_BIT] = att_r;
                d[acd_pkg::INT_DET_BIT] = det_r;
            end
            acd_pkg::REG_DEV1:
            begin
                d[acd_pkg::DEV1_SDP_BIT] = acc_r.sdp;
                d[acd_pkg::DEV1_CDP_BIT] = acc_r.cdp;
            end
            default:           d = 8'h00;
        endcase
        return d;
    endfunction

    // Read bytes for the current and the following pointer
    logic [7:0] rd_cur;
    logic [7:0] rd_inc;

    always_comb
    begin
        rd_cur = rd_byte(ptr_r);
        rd_inc = rd_byte(ptr_inc);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r      <= acd_pkg::S_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            tx_r      <= 8'h00;
            ptr_r     <= 8'h00;
            ctrl_r    <= acd_pkg::CTRL_RST;
            rw_r      <= 1'b0;
            nack_r    <= 1'b1;
            oe_r      <= 1'b0;
            rd_clr_r  <= 1'b0;
        end
        else
        begin
            rd_clr_r <= 1'b0;
            if (i2c_start)
            begin
                st_r      <= acd_pkg::S_ADDR;
                bit_cnt_r <= 4'h0;
                oe_r      <= 1'b0;
            end
            else if (i2c_stop)
            begin
                st_r <= acd_pkg::S_IDLE;
                oe_r <= 1'b0;
            end
            else if (scl_rise)
            begin
                if (st_r == acd_pkg::S_RACK)
                    nack_r <= sda_f_r;
                else if (st_r != acd_pkg::S_IDLE && st_r != acd_pkg::S_ACK_A
                         && st_r != acd_pkg::S_ACK_R
                         && st_r != acd_pkg::S_ACK_W)
                begin
                    shift_r   <= {shift_r[6:0], sda_f_r};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
            end
            else if (scl_fall)
            begin
                unique case (st_r)
                    acd_pkg::S_IDLE: ;
                    acd_pkg::S_ADDR:
                        if (bit_cnt_r == 4'h8)
                        begin
                            if (shift_r[7:1] == acd_pkg::SLV_ADDR)
                            begin
                                rw_r <= shift_r[0];
                                oe_r <= 1'b1;
                                st_r <= acd_pkg::S_ACK_A;
                            end
                            else
                                st_r <= acd_pkg::S_IDLE;
                        end
                    acd_pkg::S_ACK_A:
                    begin
                        bit_cnt_r <= 4'h0;
                        if (rw_r)
                        begin
                            tx_r     <= {rd_cur[6:0], 1'b0};
                            oe_r     <= ~rd_cur[7];
                            rd_clr_r <= (ptr_r == acd_pkg::REG_INT);
                            st_r     <= acd_pkg::S_RDATA;
                        end
                        else
                        begin
                            oe_r <= 1'b0;
                            st_r <= acd_pkg::S_REG;
                        end
                    end
                    acd_pkg::S_REG:
                        if (bit_cnt_r == 4'h8)
                        begin
                            ptr_r <= shift_r;
                            oe_r  <= 1'b1;
                            st_r  <= acd_pkg::S_ACK_R;
                        end
                    acd_pkg::S_ACK_R, acd_pkg::S_ACK_W:
                    begin
                        oe_r      <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        st_r      <= acd_pkg::S_WDATA;
                    end
                    acd_pkg::S_WDATA:
                        if (bit_cnt_r == 4'h8)
                        begin
                            if (ptr_r == acd_pkg::REG_CTRL)
                                ctrl_r <= shift_r;
                            ptr_r <= ptr_inc;
                            oe_r  <= 1'b1;
                            st_r  <= acd_pkg::S_ACK_W;
                        end
                    acd_pkg::S_RDATA:
                        if (bit_cnt_r == 4'h8)
                        begin
                            oe_r <= 1'b0;
                            st_r <= acd_pkg::S_RACK;
                        end
                        else
                        begin
                            oe_r <= ~tx_r[7];
                            tx_r <= {tx_r[6:0], 1'b0};
                        end
                    acd_pkg::S_RACK:
                        if (!nack_r)
                        begin
                            ptr_r     <= ptr_inc;
                            bit_cnt_r <= 4'h0;
                            tx_r      <= {rd_inc[6:0], 1'b0};
                            oe_r      <= ~rd_inc[7];
                            rd_clr_r  <= (ptr_inc == acd_pkg::REG_INT);
                            st_r      <= acd_pkg::S_RDATA;
                        end
                        else
                            st_r <= acd_pkg::S_IDLE;
                endcase
            end
        end
    end

    chk_addr_mismatch_ignored: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (st_r == acd_pkg::S_ADDR && scl_fall && !i2c_start && !i2c_stop
         && bit_cnt_r == 4'h8 && shift_r[7:1] != acd_pkg::SLV_ADDR)
        |=> st_r == acd_pkg::S_IDLE && !oe_r)
        else $error("slave answered a foreign address");

    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_r;

    // =========================================================
    // Attach and detach flags, host interrupt
    // =========================================================
    logic         present_d_r;
    logic         mask_d_r;
    logic         irq_r;
    logic [W-1:0] dly_r;

    wire present = acc_r.sdp | acc_r.cdp | acc_r.jig;
    wire set_att = present & ~present_d_r;
    wire set_det = ~present & present_d_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            present_d_r <= 1'b0;
            att_r       <= 1'b0;
            det_r       <= 1'b0;
        end
        else
        begin
            present_d_r <= present;
            att_r       <= set_att | (att_r & ~rd_clr_r);
            det_r       <= set_det | (det_r & ~rd_clr_r);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mask_d_r <= 1'b1;
            dly_r    <= '0;
            irq_r    <= 1'b0;
        end
        else
        begin
            mask_d_r <= mask_r;
            if (mask_r)
                dly_r <= '0;
            else if (mask_d_r && (att_r || det_r))
                dly_r <= W'(P_INT_DLY_CYC);
            else if (dly_r != '0)
                dly_r <= dly_r - W'(1);
            irq_r <= ~mask_r & (set_att | set_det
                     | (dly_r == W'(1))
                     | (irq_r & ~rd_clr_r));
        end
    end

    assign host_interrupt_n_o = ~irq_r;

    chk_unmask_delay_load: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ($fell(mask_r) && (att_r || det_r)) |=> dly_r == W'(P_INT_DLY_CYC))
        else $error("unmask delay not started");
    chk_unmask_irq_fire: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (dly_r == W'(1) && !mask_r) |=> !host_interrupt_n_o)
        else $error("interrupt missing after unmask delay");
    chk_mask_blocks_irq: assert property (@(posedge clk_i)
        disable iff (rst_i)
        mask_r |=> host_interrupt_n_o)
        else $error("interrupt raised while masked");
    chk_attach_flag_set: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $rose(present) |=> att_r && ($past(mask_r) || !host_interrupt_n_o))
        else $error("attach flag or interrupt missing");
    chk_irq_held_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (!host_interrupt_n_o && !rd_clr_r && !mask_r) |=> !host_interrupt_n_o)
        else $error("interrupt released before flags were read");

    // =========================================================
    // Power and jig detection timers
    // =========================================================
    logic [W-1:0] vcnt_r;
    logic [W-1:0] jcnt_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            vcnt_r <= '0;
            jcnt_r <= '0;
        end
        else
        begin
            if (!acc_r.vbus)
                vcnt_r <= '0;
            else if (vcnt_r < W'(P_JIG_CYC))
                vcnt_r <= vcnt_r + W'(1);
            if (!acc_r.jig)
                jcnt_r <= '0;
            else if (jcnt_r < W'(P_JIG_CYC))
                jcnt_r <= jcnt_r + W'(1);
        end
    end

    wire auto_ok = ctrl_r[acd_pkg::CTRL_AUTO_BIT]
                 & ~ctrl_r[acd_pkg::CTRL_OPEN_BIT];

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            closed_r <= 1'b0;
            jig_r    <= 1'b0;
        end
        else
        begin
            closed_r <= acc_r.vbus & auto_ok
                & ((acc_r.sdp & (vcnt_r >= W'(P_SDP_CYC)))
                 | (acc_r.cdp & (vcnt_r >= W'(P_CDP_CYC))));
            jig_r <= acc_r.jig & (acc_r.vbus
                ? (vcnt_r >= W'(P_JIG_CYC))
                : (jcnt_r >= W'(P_JIG_CYC)));
        end
    end

    assign usb_switch_closed_o = closed_r;
    assign factory_jig_o       = jig_r;

    chk_sdp_close_time: assert property (@(posedge clk_i) disable iff (rst_i)
        (acc_r.vbus && acc_r.sdp && auto_ok && vcnt_r == W'(P_SDP_CYC))
        |=> usb_switch_closed_o)
        else $error("switch not closed at standard port delay");
    chk_cdp_close_time: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(usb_switch_closed_o) && !acc_r.sdp |->
            $past(vcnt_r) >= W'(P_CDP_CYC))
        else $error("switch closed early for charging port");
    chk_jig_vbus_time: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(factory_jig_o) && $past(acc_r.vbus) |->
            $past(vcnt_r) >= W'(P_JIG_CYC))
        else $error("jig output early with bus power");
    chk_jig_nopwr_time: assert property (@(posedge clk_i) disable iff (rst_i)
        (acc_r.jig && !acc_r.vbus && jcnt_r == W'(P_JIG_CYC))
        |=> factory_jig_o)
        else $error("jig output missing without bus power");

endmodule

// ---- acd_host_model.sv ----
// Purpose: Host side model driving the two-wire control link
// Assumes: Open-drain wire resolved outside; sda_i is the wire level
// Notes:   glitch_i adds a 40 ns scl spike inside every data bit's high phase, not in start or stop
`timescale 1ns/100ps
module acd_host_model #(
    parameter int Q = 12
) (
    input  wire logic clk_i,
    input  wire logic sda_i,
    input  wire logic glitch_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // =========================================================
    // Bit level
    // =========================================================
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic clk_bit(input logic b, output logic r);
        scl_o <= 1'b0;
        hold(Q);
        sda_low_o <= ~b;
        hold(Q);
        scl_o <= 1'b1;
        hold(Q);
        r = sda_i;
        if (glitch_i)
        begin
            scl_o <= 1'b0;
            hold(2);
            scl_o <= 1'b1;
        end
        hold(Q);
    endtask

    // Also serves as repeated start after an acknowledge bit
    task automatic start_c;
        scl_o <= 1'b0;
        hold(Q);
        sda_low_o <= 1'b0;
        hold(Q);
        scl_o <= 1'b1;
        hold(Q);
        sda_low_o <= 1'b1;
        hold(Q);
    endtask

    task automatic stop_c;
        scl_o <= 1'b0;
        hold(Q);
        sda_low_o <= 1'b1;
        hold(Q);
        scl_o <= 1'b1;
        hold(Q);
        sda_low_o <= 1'b0;
        hold(2 * Q);
    endtask

    // =========================================================
    // Byte level, most significant bit first
    // =========================================================
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = (r === 1'b0);
    endtask

    task automatic byte_rx(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i]);
        clk_bit(nack, r);
    endtask

    task automatic probe(input logic [7:0] ab, output logic ack);
        start_c();
        byte_tx(ab, ack);
        stop_c();
    endtask

    task automatic wr(input logic [7:0] ra, input logic [7:0] d,
                      output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start_c();
        byte_tx({acd_pkg::SLV_ADDR, 1'b0}, a0);
        byte_tx(ra, a1);
        byte_tx(d, a2);
        stop_c();
        ok = a0 & a1 & a2;
    endtask

    task automatic rd(input logic [7:0] ra, output logic [7:0] d,
                      output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start_c();
        byte_tx({acd_pkg::SLV_ADDR, 1'b0}, a0);
        byte_tx(ra, a1);
        start_c();
        byte_tx({acd_pkg::SLV_ADDR, 1'b1}, a2);
        byte_rx(1'b1, d);
        stop_c();
        ok = a0 & a1 & a2;
    endtask
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for the accessory detect timing block
// Assumes: Long delays shortened through the top parameters
// Notes:   Delays are checked inside a small window after the cause
`timescale 1ns/100ps
module testbench;
    localparam int P_INT = 50;
    localparam int P_SDP = 130;
    localparam int P_CDP = 170;
    localparam int P_JIG = 200;
    localparam int TMO   = 90000;

    logic              clk_i;
    logic              rst_i;
    logic              glitch;
    logic              scl;
    logic              host_low;
    logic              sda_w;
    logic              sda_o;
    logic              sda_oe_o;
    logic              usb_o;
    logic              jig_o;
    logic              int_n_o;
    acd_pkg::acd_acc_s acc;
    int                mismatches;
    int                checks_done;
    int                cyc = 0;

    assign sda_w = ~(host_low | (sda_oe_o & ~sda_o));

    acd_top #(.P_INT_DLY_CYC(P_INT), .P_SDP_CYC(P_SDP),
              .P_CDP_CYC(P_CDP), .P_JIG_CYC(P_JIG)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .acc_i(acc),
        .usb_switch_closed_o(usb_o), .factory_jig_o(jig_o),
        .host_interrupt_n_o(int_n_o));

    acd_host_model host_u (
        .clk_i(clk_i), .sda_i(sda_w), .glitch_i(glitch),
        .scl_o(scl), .sda_low_o(host_low));

    // =========================================================
    // Clock, timeout and shared tasks
    // =========================================================
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == TMO)
        begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        host_u.wr(a, d, ok);
        check(ok, 1'b1, "write ack");
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp,
                           input string what);
        logic [7:0] d;
        logic       ok;
        host_u.rd(a, d, ok);
        check(ok, 1'b1, "read ack");
        check(d, exp, what);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return usb_o;
            1: return jig_o;
            default: return ~int_n_o;
        endcase
    endfunction

    // Cycles from applying v until the picked output rises
    task automatic meas(input logic [3:0] v, input int s, input int lo,
                        input int hi, input string what);
        int n;
        n = 0;
        acc <= acd_pkg::acd_acc_s'(v);
        @(negedge clk_i);
        while (pick(s) !== 1'b1 && n < 1000)
        begin
            @(negedge clk_i);
            n++;
        end
        @(posedge clk_i);
        check(n >= lo && n <= hi, 1'b1, what);
    endtask

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic s_reset;
        check({sda_oe_o, usb_o, jig_o, int_n_o}, 4'h1, "reset outs");
        reg_chk(acd_pkg::REG_CTRL, 8'h05, "ctrl reset");
        reg_chk(acd_pkg::REG_INT, 8'h00, "flags reset");
    endtask

    task automatic s_address;
        logic [7:0] bad [3] = '{8'h4C, 8'h4D, 8'hCA};
        logic       a;
        foreach (bad[i])
        begin
            host_u.probe(bad[i], a);
            check(a, 1'b0, "foreign ack");
        end
        host_u.probe({acd_pkg::SLV_ADDR, 1'b0}, a);
        check(a, 1'b1, "own ack");
    endtask

    task automatic s_glitch;
        glitch <= 1'b1;
        reg_wr(acd_pkg::REG_CTRL, 8'h15);
        reg_chk(acd_pkg::REG_CTRL, 8'h15, "ctrl glitched");
        reg_wr(acd_pkg::REG_CTRL, 8'h05);
        glitch <= 1'b0;
    endtask

    task automatic s_std_port;
        int n;
        meas(4'b1100, 0, P_SDP, P_SDP + 8, "sdp delay");
        check(int_n_o, 1'b1, "masked int");
        reg_chk(acd_pkg::REG_DEV1, 8'h04, "sdp status");
        n = 0;
        fork
            reg_wr(acd_pkg::REG_CTRL, 8'h04);
            begin
                repeat (3) @(posedge sda_oe_o);
                while (int_n_o !== 1'b0 && n < 1000)
                begin
                    @(posedge clk_i);
                    n++;
                end
            end
        join
        check(n >= P_INT - 2 && n <= P_INT + 6, 1'b1, "unmask");
        host_u.hold(100);
        check(int_n_o, 1'b0, "int held");
        reg_chk(acd_pkg::REG_INT, 8'h01, "attach flag");
        check(int_n_o, 1'b1, "int released");
        reg_chk(acd_pkg::REG_INT, 8'h00, "flags cleared");
    endtask

    task automatic s_charge_port;
        meas(4'b0000, 2, 0, 8, "detach int");
        check(usb_o, 1'b0, "switch opens");
        reg_chk(acd_pkg::REG_INT, 8'h02, "detach flag");
        meas(4'b1010, 0, P_CDP, P_CDP + 8, "cdp delay");
        reg_chk(acd_pkg::REG_INT, 8'h01, "attach flag");
    endtask

    task automatic s_jig;
        reg_wr(acd_pkg::REG_CTRL, 8'h05);
        acc <= '0;
        host_u.hold(20);
        meas(4'b1001, 1, P_JIG, P_JIG + 8, "jig vbus");
        check(int_n_o, 1'b1, "masked int");
        acc <= '0;
        host_u.hold(20);
        check(jig_o, 1'b0, "jig drops");
        meas(4'b0001, 1, P_JIG, P_JIG + 8, "jig alone");
        acc <= '0;
    endtask

    initial
    begin
        rst_i = 1'b1;
        glitch = 1'b0;
        acc = '0;
        mismatches = 0;
        checks_done = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        s_reset();
        s_address();
        s_glitch();
        s_std_port();
        s_charge_port();
        s_jig();
        wrap_up();
    end
endmodule
